// ---- spim_map.svh ----
`ifndef SPIM_MAP_SVH
`define SPIM_MAP_SVH

// register byte addresses
`define SPIM_ADDR_W 21
`define SPIM_PAD_SEL_OFS 21'h17580
`define SPIM_CLK_CFG_OFS 21'h104800
`define SPIM_CLK_STS_OFS 21'h10480C
`define SPIM_FORMAT_OFS 21'h104810
`define SPIM_FORCE_OFS 21'h104814
`define SPIM_STALL_OFS 21'h104824
`define SPIM_MODE_OFS 21'h104830
`define SPIM_RESULT_OFS 21'h104900
`define SPIM_LAUNCH_OFS 21'h104A00
`define SPIM_CANCEL_OFS 21'h104A04
`define SPIM_WORDCMD_OFS 21'h104A08
`define SPIM_TXLEN_OFS 21'h104A0C
`define SPIM_RXLEN_OFS 21'h104A20
`define SPIM_TXBLK_OFS 21'h104A24
`define SPIM_RXBLK_OFS 21'h104A28
`define SPIM_HANDSHAKE_OFS 21'h104A2C
`define SPIM_PREAMBLE_OFS 21'h104A30
`define SPIM_ACTIVITY_OFS 21'h104B00
`define SPIM_TXCNT_OFS 21'h104B04
`define SPIM_RXCNT_OFS 21'h104B08
`define SPIM_TXDATA_OFS 21'h104C00
`define SPIM_RXDATA_OFS 21'h104E00

// field positions
`define SPIM_PAD_SEL_BIT 8
`define SPIM_IDLE_LSB 24
`define SPIM_DELAY_LSB 16
`define SPIM_WIRE3_BIT 8
`define SPIM_DPHA_BIT 6
`define SPIM_CPHA_BIT 5
`define SPIM_CPOL_BIT 4
`define SPIM_STALL_BIT 16
`define SPIM_WSIZE_LSB 16
`define SPIM_PRE_EN_BIT 24
`define SPIM_RXDONE_BIT 4
`define SPIM_TXDONE_BIT 0
`define SPIM_BUSY_BIT 8
`define SPIM_RXREQ_BIT 4
`define SPIM_TXREQ_BIT 0

// reset values
`define SPIM_PAD_SEL_RST 1'b1

// timing
`define SPIM_PCLK_MHZ 100
`define SPIM_RATE_LSB_PER_MHZ 64
`define SPIM_MIN_HALF 6'h02

`endif

// ---- spim_pkg.sv ----
package spim_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LEAD = 5'b00010,
		ST_SHIFT = 5'b00100,
		ST_LAG = 5'b01000,
		ST_GAP = 5'b10000
	} spim_state_type;

	typedef enum logic [2:0] {
		PH_PRE = 3'b001,
		PH_TX = 3'b010,
		PH_RX = 3'b100
	} spim_phase_type;

	typedef enum logic [1:0] {
		CMD_WRITE = 2'b00,
		CMD_READ = 2'b01,
		CMD_WTR = 2'b10
	} spim_cmd_type;

	typedef struct packed {
		logic sck;
		logic [2:0] ss_n;
		logic mosi_o;
		logic mosi_oe;
	} spim_pins_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} spim_byte_type;

endpackage

// ---- spim_master.sv ----
`timescale 1ns/1ps
`include "spim_map.svh"

// Operation
// - idle gap between transactions from code
// - lead and lag select delay from code
// - three-wire mode shares output data line
// - sample half or full period after data
// - clock phase picks odd or even edges
// - clock polarity sets idle clock level
// - select field picks one of three selects
// - force bit holds chosen select low
// - block-finished flag per DMA block, cleared
// - error flag, cleared by launch or mode-off
// - cancelled and finished flags, cleared by launch
// - launch starts, cancel terminates transaction
// - word width sets byte order, MSB first
// - command selects write, read, write-read
// - lengths are bytes minus one
// - block intervals set event spacing
// - receive consumed clears receive waiting
// - transmit filled clears transmit space free
// - DMA write sends header bytes first
// - active flag high throughout transaction
// - receive waiting shows buffered data
// - transmit space free shows buffer free
module spim_master #(
	parameter int TX_WORDS = 16,
	parameter int RX_WORDS = 16
)(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset
	input wire logic ce, // clock enable
	input wire logic [`SPIM_ADDR_W-1:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error
	output spim_pkg::spim_pins_type pins, // serial pins out
	input wire logic mosi_in, // shared data line in
	input wire logic miso_in, // master in line
	input wire spim_pkg::spim_byte_type dma_tx_in, // dma data source
	output logic dma_tx_ready, // dma byte taken
	output spim_pkg::spim_byte_type dma_rx_out, // dma received byte
	input wire logic dma_error_in // dma fault pulse
);
	import spim_pkg::*;

	function automatic logic [3:0] halves(input logic [3:0] code);
		halves = (code < 4'h2) ? 4'h1 : code;
	endfunction

	// byte lane within a word for the k-th byte on the wire
	function automatic logic [1:0] lane(input logic [1:0] ws, input logic [1:0] k);
		unique case (ws)
			2'b00: lane = k;
			2'b01: lane = {k[1], ~k[0]};
			default: lane = ~k;
		endcase
	endfunction

	logic pad_sel;
	logic [5:0] clk_code;
	logic [3:0] idle_code, delay_code;
	logic wire3, dpha, cpha, cpol;
	logic [2:0] ss_choice;
	logic force_ss, stall_en, dma_mode, pre_en;
	logic [1:0] wsize, cmd;
	logic [21:0] tx_len, rx_len, tx_cnt, rx_cnt, left;
	logic [5:0] tx_blk, rx_blk, pre_len, pre_left, blk, hc, half_len;
	logic blk_done, dma_err, aborted, done_ok;
	spim_state_type st;
	spim_phase_type ph;
	logic [3:0] dcnt;
	logic [31:0] tx_mem [TX_WORDS];
	logic [31:0] rx_mem [RX_WORDS];
	logic [3:0] tx_wr, rx_rd;
	logic [5:0] tx_rd, rx_wr;
	logic tx_full, rx_waiting;
	logic [2:0] miso_s, mosi_s;
	logic miso_v, mosi_v;
	logic loaded, half;
	logic [2:0] bit_idx;
	logic [7:0] sh_tx, sh_rx;
	logic [31:0] rd_word;
	logic rd_hit;

	wire acc = psel & penable;
	wire wr = ce & acc & pwrite;
	wire rd = ce & acc & ~pwrite;
	wire launch = wr && paddr == `SPIM_LAUNCH_OFS && pwdata[0] && pad_sel;
	wire cancel = wr && paddr == `SPIM_CANCEL_OFS && pwdata[0];
	wire hs_wr = wr && paddr == `SPIM_HANDSHAKE_OFS;
	wire tx_commit = hs_wr && pwdata[`SPIM_TXDONE_BIT];
	wire rx_consumed = hs_wr && pwdata[`SPIM_RXDONE_BIT];
	wire busy = st != ST_IDLE;
	wire start_ok = launch && !busy;
	wire ph_pre = ph == PH_PRE;
	wire ph_tx = ph == PH_TX;
	wire ph_rx = ph == PH_RX;
	wire tx_from_dma = dma_mode && cmd == CMD_WRITE;
	wire [5:0] cur_blk = ph_rx ? rx_blk : tx_blk;
	wire tick = busy && hc == half_len - 6'h01;
	wire in_bit = wire3 ? mosi_v : miso_v;
	wire byte_end = st == ST_SHIFT && loaded && tick && half && bit_idx == 3'h0;
	wire blk_ev = byte_end && !ph_pre && (blk == cur_blk || left == 22'h0);
	wire [7:0] rx_byte = dpha ? {sh_rx[6:0], in_bit} : sh_rx;
	wire [7:0] tx_byte = tx_mem[tx_rd[5:2]][{lane(wsize, tx_rd[1:0]), 3'b000} +: 8];
	logic src_ok;
	wire take = st == ST_SHIFT && !loaded && src_ok;

	assign pready = 1'b1;
	assign half_len = (clk_code < `SPIM_MIN_HALF) ? `SPIM_MIN_HALF : clk_code;
	assign dma_tx_ready = take && ph_tx && tx_from_dma;

	// data waits while the source has nothing; with stall off the stale byte goes out
	always_comb
	begin
		src_ok = 1'b1;
		if (ph_pre || (ph_tx && !tx_from_dma))
			src_ok = tx_full;
		else if (ph_tx)
			src_ok = dma_tx_in.valid;
		else if (!dma_mode)
			src_ok = !rx_waiting;
		src_ok = src_ok | ~stall_en;
	end

	// input synchronisers: a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			miso_s <= 3'h0;
			mosi_s <= 3'h0;
			miso_v <= 1'b0;
			mosi_v <= 1'b0;
		end
		else if (ce)
		begin
			miso_s <= {miso_s[1:0], miso_in};
			mosi_s <= {mosi_s[1:0], mosi_in};
			if (miso_s[1] == miso_s[2])
				miso_v <= miso_s[2];
			if (mosi_s[1] == mosi_s[2])
				mosi_v <= mosi_s[2];
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_sel <= `SPIM_PAD_SEL_RST;
			clk_code <= 6'h00;
			idle_code <= 4'h0;
			delay_code <= 4'h0;
			{wire3, dpha, cpha, cpol} <= 4'h0;
			ss_choice <= 3'h0;
			force_ss <= 1'b0;
			stall_en <= 1'b0;
			dma_mode <= 1'b0;
			wsize <= 2'h0;
			cmd <= 2'h0;
			tx_len <= 22'h0;
			rx_len <= 22'h0;
			tx_blk <= 6'h00;
			rx_blk <= 6'h00;
			pre_en <= 1'b0;
			pre_len <= 6'h00;
		end
		else if (wr)
		begin
			unique case (paddr)
				`SPIM_PAD_SEL_OFS: pad_sel <= pwdata[`SPIM_PAD_SEL_BIT];
				`SPIM_CLK_CFG_OFS: clk_code <= pwdata[5:0];
				`SPIM_FORMAT_OFS:
				begin
					idle_code <= pwdata[`SPIM_IDLE_LSB +: 4];
					delay_code <= pwdata[`SPIM_DELAY_LSB +: 4];
					wire3 <= pwdata[`SPIM_WIRE3_BIT];
					dpha <= pwdata[`SPIM_DPHA_BIT];
					cpha <= pwdata[`SPIM_CPHA_BIT];
					cpol <= pwdata[`SPIM_CPOL_BIT];
					ss_choice <= pwdata[2:0];
				end
				`SPIM_FORCE_OFS: force_ss <= pwdata[0];
				`SPIM_STALL_OFS: stall_en <= pwdata[`SPIM_STALL_BIT];
				`SPIM_MODE_OFS: dma_mode <= pwdata[0];
				`SPIM_WORDCMD_OFS:
				begin
					wsize <= pwdata[`SPIM_WSIZE_LSB +: 2];
					cmd <= pwdata[1:0];
				end
				`SPIM_TXLEN_OFS: tx_len <= pwdata[21:0];
				`SPIM_RXLEN_OFS: rx_len <= pwdata[21:0];
				`SPIM_TXBLK_OFS: tx_blk <= pwdata[5:0];
				`SPIM_RXBLK_OFS: rx_blk <= pwdata[5:0];
				`SPIM_PREAMBLE_OFS:
				begin
					pre_en <= pwdata[`SPIM_PRE_EN_BIT];
					pre_len <= pwdata[5:0];
				end
				default: ;
			endcase
		end
	end

	always_comb
	begin
		rd_hit = 1'b1;
		rd_word = 32'h0;
		unique case (paddr)
			`SPIM_PAD_SEL_OFS: rd_word = {23'h0, pad_sel, 8'h00};
			`SPIM_CLK_CFG_OFS: rd_word = {26'h0, clk_code};
			`SPIM_CLK_STS_OFS: rd_word = {16'h0, 16'((`SPIM_PCLK_MHZ * `SPIM_RATE_LSB_PER_MHZ)
				/ (2 * int'(half_len)))};
			`SPIM_FORMAT_OFS: rd_word = {4'h0, idle_code, 4'h0, delay_code, 7'h00, wire3,
				1'b0, dpha, cpha, cpol, 1'b0, ss_choice};
			`SPIM_FORCE_OFS: rd_word = {31'h0, force_ss};
			`SPIM_STALL_OFS: rd_word = {15'h0, stall_en, 16'h0};
			`SPIM_MODE_OFS: rd_word = {31'h0, dma_mode};
			`SPIM_RESULT_OFS: rd_word = {28'h0, blk_done, dma_err, aborted, done_ok};
			`SPIM_WORDCMD_OFS: rd_word = {14'h0, wsize, 14'h0, cmd};
			`SPIM_TXLEN_OFS: rd_word = {10'h0, tx_len};
			`SPIM_RXLEN_OFS: rd_word = {10'h0, rx_len};
			`SPIM_TXBLK_OFS: rd_word = {26'h0, tx_blk};
			`SPIM_RXBLK_OFS: rd_word = {26'h0, rx_blk};
			`SPIM_PREAMBLE_OFS: rd_word = {7'h0, pre_en, 18'h0, pre_len};
			`SPIM_ACTIVITY_OFS: rd_word = {23'h0, busy, 3'h0, rx_waiting, 3'h0, ~tx_full};
			`SPIM_TXCNT_OFS: rd_word = {10'h0, tx_cnt};
			`SPIM_RXCNT_OFS: rd_word = {10'h0, rx_cnt};
			`SPIM_RXDATA_OFS: rd_word = rx_mem[rx_rd];
			`SPIM_LAUNCH_OFS, `SPIM_CANCEL_OFS, `SPIM_HANDSHAKE_OFS, `SPIM_TXDATA_OFS: ;
			default: rd_hit = 1'b0;
		endcase
	end

	// answer captured in the setup cycle so the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (ce && psel && !penable)
		begin
			prdata <= pwrite ? 32'h0 : rd_word;
			pslverr <= ~rd_hit;
		end
	end

	// half-period timer, restarted whenever a byte is waiting on its source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hc <= 6'h00;
		else if (ce)
		begin
			if (!busy || (st == ST_SHIFT && !loaded) || tick)
				hc <= 6'h00;
			else
				hc <= hc + 6'h01;
		end
	end

	// transaction sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= ST_IDLE;
			ph <= PH_TX;
			dcnt <= 4'h0;
			left <= 22'h0;
			pre_left <= 6'h00;
			blk <= 6'h00;
		end
		else if (ce)
		begin
			if (cancel && busy && st != ST_GAP)
			begin
				st <= ST_GAP;
				dcnt <= 4'h0;
			end
			else
			begin
				unique case (st)
					ST_IDLE:
						if (start_ok)
						begin
							st <= ST_LEAD;
							dcnt <= 4'h0;
							blk <= 6'h00;
							pre_left <= pre_len;
							left <= (cmd == CMD_READ) ? rx_len : tx_len;
							if (cmd == CMD_READ)
								ph <= PH_RX;
							else if (tx_from_dma && pre_en)
								ph <= PH_PRE;
							else
								ph <= PH_TX;
						end
					ST_LEAD:
						if (tick)
						begin
							dcnt <= dcnt + 4'h1;
							if (dcnt == halves(delay_code) - 4'h1)
								st <= ST_SHIFT;
						end
					ST_SHIFT:
						if (byte_end)
						begin
							if (ph_pre)
							begin
								pre_left <= pre_left - 6'h01;
								if (pre_left == 6'h00)
									ph <= PH_TX;
							end
							else
							begin
								blk <= (blk == cur_blk) ? 6'h00 : blk + 6'h01;
								left <= left - 22'h1;
								if (left == 22'h0)
								begin
									if (ph_tx && cmd == CMD_WTR)
									begin
										ph <= PH_RX;
										left <= rx_len;
										blk <= 6'h00;
									end
									else
									begin
										st <= ST_LAG;
										dcnt <= 4'h0;
									end
								end
							end
						end
					ST_LAG:
						if (tick)
						begin
							dcnt <= dcnt + 4'h1;
							if (dcnt == halves(delay_code) - 4'h1)
							begin
								st <= ST_GAP;
								dcnt <= 4'h0;
							end
						end
					ST_GAP:
						if (tick)
						begin
							dcnt <= dcnt + 4'h1;
							if (dcnt == halves(idle_code) - 4'h1)
								st <= ST_IDLE;
						end
				endcase
			end
		end
	end

	// bit engine: each bit spans two half periods
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			loaded <= 1'b0;
			half <= 1'b0;
			bit_idx <= 3'h0;
			sh_tx <= 8'h00;
			sh_rx <= 8'h00;
		end
		else if (ce)
		begin
			if (st != ST_SHIFT)
			begin
				loaded <= 1'b0;
				half <= 1'b0;
			end
			else if (take)
			begin
				loaded <= 1'b1;
				half <= 1'b0;
				bit_idx <= 3'h7;
				sh_tx <= ph_rx ? 8'h00 : (ph_tx && tx_from_dma) ? dma_tx_in.data : tx_byte;
			end
			else if (loaded && tick)
			begin
				half <= ~half;
				if (!half && !dpha)
					sh_rx <= {sh_rx[6:0], in_bit};
				if (half)
				begin
					if (dpha)
						sh_rx <= {sh_rx[6:0], in_bit};
					if (bit_idx == 3'h0)
						loaded <= 1'b0;
					else
					begin
						bit_idx <= bit_idx - 3'h1;
						sh_tx <= {sh_tx[6:0], 1'b0};
					end
				end
			end
		end
	end

	// transmit buffer; a commit in the same cycle as a release wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_wr <= 4'h0;
			tx_rd <= 6'h00;
			tx_full <= 1'b0;
		end
		else if (ce)
		begin
			if (wr && paddr == `SPIM_TXDATA_OFS)
				tx_wr <= tx_wr + 4'h1;
			if (byte_end && (ph_pre || (ph_tx && !tx_from_dma)))
				tx_rd <= tx_rd + 6'h01;
			// a launch rewinds the buffer but keeps data that a write still has to send
			if (start_ok)
				tx_rd <= 6'h00;
			if ((byte_end && ph_pre && pre_left == 6'h00) || (blk_ev && ph_tx && !tx_from_dma)
				|| (start_ok && cmd == CMD_READ))
			begin
				tx_full <= 1'b0;
				tx_rd <= 6'h00;
			end
			if (tx_commit)
			begin
				tx_full <= 1'b1;
				tx_wr <= 4'h0;
			end
		end
	end

	always_ff @(posedge pclk)
	begin
		if (ce && wr && paddr == `SPIM_TXDATA_OFS)
			tx_mem[tx_wr] <= pwdata;
		if (ce && byte_end && ph_rx && !dma_mode)
			rx_mem[rx_wr[5:2]][{lane(wsize, rx_wr[1:0]), 3'b000} +: 8] <= rx_byte;
	end

	// receive buffer; a block landing as software consumes keeps the flag set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_wr <= 6'h00;
			rx_rd <= 4'h0;
			rx_waiting <= 1'b0;
		end
		else if (ce)
		begin
			if (rd && paddr == `SPIM_RXDATA_OFS)
				rx_rd <= rx_rd + 4'h1;
			if (rx_consumed)
			begin
				rx_waiting <= 1'b0;
				rx_rd <= 4'h0;
			end
			if (byte_end && ph_rx && !dma_mode)
				rx_wr <= rx_wr + 6'h01;
			if (blk_ev && ph_rx && !dma_mode)
			begin
				rx_waiting <= 1'b1;
				rx_wr <= 6'h00;
			end
		end
	end

	// result flags: hardware sets win over clears
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{blk_done, dma_err, aborted, done_ok} <= 4'h0;
			tx_cnt <= 22'h0;
			rx_cnt <= 22'h0;
		end
		else if (ce)
		begin
			if (start_ok || (wr && paddr == `SPIM_RESULT_OFS && pwdata[3]))
				blk_done <= 1'b0;
			if (start_ok || (wr && paddr == `SPIM_MODE_OFS && !pwdata[0]))
				dma_err <= 1'b0;
			if (start_ok)
			begin
				aborted <= 1'b0;
				done_ok <= 1'b0;
				tx_cnt <= 22'h0;
				rx_cnt <= 22'h0;
			end
			if (byte_end && ph_tx)
				tx_cnt <= tx_cnt + 22'h1;
			if (byte_end && ph_rx)
				rx_cnt <= rx_cnt + 22'h1;
			if (blk_ev && dma_mode)
				blk_done <= 1'b1;
			if (dma_error_in && dma_mode && busy)
				dma_err <= 1'b1;
			if (cancel && busy && st != ST_GAP)
				aborted <= 1'b1;
			if (st == ST_LAG && tick && dcnt == halves(delay_code) - 4'h1)
				done_ok <= 1'b1;
		end
	end

	// pins and dma receive strobe, all from flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pins <= '{sck: 1'b0, ss_n: 3'b111, mosi_o: 1'b0, mosi_oe: 1'b1};
			dma_rx_out <= '0;
		end
		else if (ce)
		begin
			// cpha 0: first edge mid-bit; cpha 1: first edge at bit start
			pins.sck <= cpol ^ (loaded && (half ^ cpha));
			for (int i = 0; i < 3; i++)
				pins.ss_n[i] <= ~(ss_choice == 3'(i) && (force_ss
					|| st == ST_LEAD || st == ST_SHIFT || st == ST_LAG));
			pins.mosi_o <= sh_tx[7];
			pins.mosi_oe <= ~(wire3 && ph_rx
				&& (st == ST_LEAD || st == ST_SHIFT || st == ST_LAG));
			dma_rx_out.valid <= byte_end && ph_rx && dma_mode;
			if (byte_end && ph_rx)
				dma_rx_out.data <= rx_byte;
		end
	end

endmodule

// ---- spim_master_asserts.sv ----
`timescale 1ns/1ps
module spim_master_asserts (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic pready, // apb ready
	input wire logic [31:0] prdata, // apb read data
	input wire spim_pkg::spim_pins_type pins // serial pins
);
	import spim_pkg::*;
	int quiet;
	// a polarity write may legally move an idle clock, so it restarts the count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			quiet <= 0;
		else if ((psel && pwrite) || !(&pins.ss_n))
			quiet <= 0;
		else if (quiet < 15)
			quiet <= quiet + 1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence sel_drop;
		$fell(&pins.ss_n);
	endsequence
	sequence sel_lift;
		$rose(&pins.ss_n);
	endsequence
	lead_quiet_a: assert property (sel_drop |-> $stable(pins.sck)[*2])
		else $error("clock moved inside lead delay");
	frame_hold_a: assert property (sel_drop |-> (!(&pins.ss_n))[*8])
		else $error("select released too early");
	gap_hold_a: assert property (sel_lift |-> (&pins.ss_n)[*2])
		else $error("idle gap too short");
	sck_idle_a: assert property (quiet >= 3 |-> $stable(pins.sck))
		else $error("clock moved while idle");
	one_select_a: assert property ($countones(~pins.ss_n) <= 1)
		else $error("several selects low");
	shared_line_a: assert property (!pins.mosi_oe |-> !(&pins.ss_n))
		else $error("data line released outside frame");
	prdata_hold_a: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved in access");
	ready_seen_a: assert property (psel && penable |-> pready)
		else $error("ready low in access");
endmodule
bind spim_master spim_master_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pins(pins));

// ---- spim_slave_model.sv ----
`timescale 1ns/1ps
module spim_slave_model (
	input wire logic pclk, // bus clock
	input wire spim_pkg::spim_pins_type pins, // master pins
	input wire logic cpol, // idle clock level
	input wire logic cpha, // clock phase
	input wire logic [7:0] reply, // byte to return
	output logic miso, // data toward master
	output logic got, // byte captured pulse
	output logic [7:0] rx_byte // captured byte
);
	import spim_pkg::*;
	logic sck_q = 1'b0;
	logic ss_q = 1'b1;
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'h00;
	int n = 0;
	logic moved;
	logic samp;
	assign moved = pins.sck != sck_q;
	assign samp = moved && (pins.sck == (cpol ^ !cpha));
	initial
	begin
		miso = 1'b0;
		got = 1'b0;
		rx_byte = 8'h00;
	end
	always @(posedge pclk)
	begin
		sck_q <= pins.sck;
		ss_q <= pins.ss_n[0];
		got <= 1'b0;
		if (pins.ss_n[0])
		begin
			n <= 0;
			tx <= reply;
			miso <= ~miso; // deselected line carries no stale bit
		end
		else if (samp)
		begin
			sh <= {sh[6:0], pins.mosi_o};
			n <= (n == 7) ? 0 : n + 1;
			if (n == 7)
			begin
				got <= 1'b1;
				rx_byte <= {sh[6:0], pins.mosi_o};
				tx <= reply;
			end
		end
		else if (moved || (ss_q && !cpha))
		begin
			miso <= tx[7];
			tx <= {tx[6:0], 1'b0};
		end
	end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "spim_map.svh"
module tb_top;
	import spim_pkg::*;
	localparam logic [32:0] ALL = 33'h1FFFFFFFF;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [20:0] paddr = 21'h0;
	logic [31:0] pwdata = 32'h0;
	logic chk = 1'b0;
	logic wchk = 1'b0;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic [7:0] reply = 8'h00;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	spim_pins_type pins;
	logic miso;
	logic got;
	logic [7:0] rx_byte;
	logic [32:0] eq[$];
	logic [32:0] mq[$];
	logic [7:0] bq[$];
	logic [31:0] r;
	logic [31:0] d;
	int err_count = 0;
	int num_checks = 0;
	int i;
	int w;
	int j;
	initial forever #5 pclk = ~pclk;
	spim_master dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pins(pins),
		.mosi_in(pins.mosi_oe ? pins.mosi_o : miso), .miso_in(miso), .dma_tx_in('0),
		.dma_tx_ready(), .dma_rx_out(), .dma_error_in(1'b0));
	spim_slave_model peer (.pclk(pclk), .pins(pins), .cpol(cpol), .cpha(cpha),
		.reply(reply), .miso(miso), .got(got), .rx_byte(rx_byte));
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task bad(input string s);
		err_count++;
		$display("ERROR %0t %s", $time, s);
	endtask
	task apb(input logic wr_en, input logic [20:0] a, input logic [31:0] v, input logic c);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= v;
		chk <= c;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk <= 1'b0;
	endtask
	task wr(input logic [20:0] a, input logic [31:0] v);
		apb(1'b1, a, v, 1'b0);
	endtask
	task rd(input logic [20:0] a, input logic [32:0] e, input logic [32:0] m);
		eq.push_back(e & m);
		mq.push_back(m);
		apb(1'b0, a, 32'h0, 1'b1);
	endtask
	task wait_idle;
		do apb(1'b0, `SPIM_ACTIVITY_OFS, 32'h0, 1'b0); while (r[8] !== 1'b0);
	endtask
	always @(posedge pclk)
	begin
		if (chk && psel && penable && !pwrite)
		begin
			num_checks++;
			if (({pslverr, prdata} & mq[0]) !== eq[0])
				bad("read value");
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
		if (got === 1'b1 && wchk)
		begin
			num_checks++;
			if (bq.size() == 0)
				bad("extra byte");
			else if (rx_byte !== bq.pop_front())
				bad("byte value");
		end
	end
	initial
	begin
		#300000;
		bad("timeout");
		conclude();
	end
	initial
	begin
		void'($urandom(32'h7C509FCA));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SPIM_PAD_SEL_OFS, 33'h100, 33'h100);
		rd(`SPIM_FORCE_OFS, 33'h0, ALL);
		rd(`SPIM_STALL_OFS, 33'h0, ALL);
		rd(`SPIM_MODE_OFS, 33'h0, ALL);
		rd(`SPIM_RESULT_OFS, 33'h0, 33'hF);
		rd(`SPIM_TXLEN_OFS, 33'h0, ALL);
		rd(`SPIM_ACTIVITY_OFS, 33'h0, 33'h110);
		rd(`SPIM_LAUNCH_OFS, 33'h0, ALL);
		rd(21'h000004, 33'h100000000, ALL);
		wr(`SPIM_PAD_SEL_OFS, 32'h100);
		wr(`SPIM_STALL_OFS, 32'h10000);
		wr(`SPIM_CLK_CFG_OFS, 32'h8);
		rd(`SPIM_CLK_STS_OFS, 33'h190, ALL);
		$display("test registers done");
		wchk <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			w = i % 3;
			d = $urandom;
			cpol <= i[0];
			cpha <= i[1];
			wr(`SPIM_FORMAT_OFS, (i << 24) | ((i + 1) << 16) | (i << 4));
			wr(`SPIM_WORDCMD_OFS, w << 16);
			wr(`SPIM_TXLEN_OFS, (1 << w) - 1);
			wr(`SPIM_TXBLK_OFS, (1 << w) - 1);
			wr(`SPIM_TXDATA_OFS, d);
			for (j = (1 << w) - 1; j >= 0; j--)
				bq.push_back(d[8 * j +: 8]);
			wr(`SPIM_HANDSHAKE_OFS, 32'h1);
			if (i == 0)
				rd(`SPIM_ACTIVITY_OFS, 33'h0, 33'h1);
			wr(`SPIM_LAUNCH_OFS, 32'h1);
			rd(`SPIM_ACTIVITY_OFS, 33'h100, 33'h100);
			wr(`SPIM_LAUNCH_OFS, 32'h1);
			wait_idle();
			rd(`SPIM_RESULT_OFS, 33'h1, 33'h3);
			rd(`SPIM_ACTIVITY_OFS, 33'h1, 33'h111);
			$display("test write mode %0d done", i);
		end
		wchk <= 1'b0;
		cpol <= 1'b0;
		cpha <= 1'b0;
		for (i = 0; i < 2; i++)
		begin
			reply <= 8'($urandom);
			wr(`SPIM_FORMAT_OFS, (i << 8) | 32'h20000);
			wr(`SPIM_WORDCMD_OFS, 32'h1);
			wr(`SPIM_RXLEN_OFS, 32'h0);
			wr(`SPIM_RXBLK_OFS, 32'h0);
			wr(`SPIM_LAUNCH_OFS, 32'h1);
			wait_idle();
			rd(`SPIM_ACTIVITY_OFS, 33'h10, 33'h10);
			rd(`SPIM_RXDATA_OFS, {25'h0, reply}, 33'hFF);
			wr(`SPIM_HANDSHAKE_OFS, 32'h10);
			rd(`SPIM_ACTIVITY_OFS, 33'h0, 33'h10);
			$display("test read wires %0d done", i);
		end
		wr(`SPIM_FORMAT_OFS, 32'h0);
		wr(`SPIM_WORDCMD_OFS, 32'h20000);
		wr(`SPIM_TXLEN_OFS, 32'h3);
		wr(`SPIM_TXDATA_OFS, $urandom);
		wr(`SPIM_HANDSHAKE_OFS, 32'h1);
		wr(`SPIM_LAUNCH_OFS, 32'h1);
		while (pins.ss_n[0] !== 1'b0) @(posedge pclk);
		repeat (10) @(posedge pclk);
		wr(`SPIM_CANCEL_OFS, 32'h1);
		wait_idle();
		rd(`SPIM_RESULT_OFS, 33'h2, 33'h3);
		$display("test cancel done");
		for (i = 0; i < 4; i++)
		begin
			wr(`SPIM_FORMAT_OFS, i);
			wr(`SPIM_FORCE_OFS, 32'h1);
			repeat (8) @(posedge pclk);
			num_checks++;
			if (pins.ss_n !== ((i < 3) ? ~(3'b001 << i) : 3'b111))
				bad("forced select");
			wr(`SPIM_FORCE_OFS, 32'h0);
			repeat (4) @(posedge pclk);
			num_checks++;
			if (pins.ss_n !== 3'b111)
				bad("select not released");
		end
		$display("test force done");
		num_checks++;
		if (bq.size() != 0)
			bad("missing byte");
		conclude();
	end
endmodule
